// [logic/power_switch_control.sv]
// Purpose: Automatic and manual control of the power switches.
// Assumes: Commands come from same-clock logic; condition pins are async.
// Notes:   Switch outputs are registered, so each decision lands one
//          cycle after the state that caused it.
`timescale 1ns/1ps
`default_nettype none

module power_switch_control
	import power_switch_pkg::*;
#(
	parameter int unsigned MS_CYCLES_P = MS_CYCLES
) (
	input  wire logic                          clock,
	input  wire logic                          rst_b,
	input  wire logic                          mode_write,
	input  wire logic [2:0]                    mode_index,
	input  wire logic                          mode_value,
	input  wire logic                          request_write,
	input  wire logic [2:0]                    request_index,
	input  wire logic                          request_value,
	input  wire logic [2:0]                    query_index,
	output var  logic                          query_request,
	output var  logic                          query_actual,
	input  wire logic                          config_write,
	input  wire logic [1:0]                    config_channel,
	input  wire power_switch_pkg::config_item_type config_item,
	input  wire logic [15:0]                   config_value,
	input  wire logic                          mgmt_pack_enable,
	input  wire logic                          mgmt_load_enable,
	input  wire logic                          mgmt_aux_enable,
	input  wire logic [15:0]                   load_current,
	input  wire logic [15:0]                   charge_current,
	input  wire logic                          charger_present,
	input  wire logic                          charger_inverted,
	input  wire logic                          over_voltage,
	input  wire logic                          under_voltage,
	input  wire logic                          over_temperature,
	input  wire logic                          under_temperature,
	input  wire logic                          load_short,
	input  wire logic                          charge_short,
	input  wire logic                          error_clear,
	output var  logic                          pack_on,
	output var  logic                          load_on,
	output var  logic                          charge_on,
	output var  logic                          aux_on,
	output var  logic                          periph_on,
	output var  logic                          inverse_charger_error,
	output var  logic                          load_overload_error,
	output var  logic                          charge_overload_error
);

	import power_switch_pkg::*;

	typedef struct packed {
		logic [6:0]        mode;
		logic [6:0]        request;
		logic [6:0]        sw;
		logic              inverse_error;
		logic              query_request;
		logic              query_actual;
		logic [16:0]       ms_count;
		logic              ms_tick;
		logic [1:0][1:0]   short_time;
		logic [1:0][15:0]  trip_level;
		logic [1:0][15:0]  trip_delay;
		logic [1:0][7:0]   max_retry;
		logic [1:0][15:0]  retry_interval;
	} control_reg_type;

	localparam control_reg_type CONTROL_RESET = '{
		mode:           MODE_RESET,
		request:        REQUEST_RESET,
		sw:             7'h00,
		inverse_error:  1'b0,
		query_request:  1'b0,
		query_actual:   1'b0,
		ms_count:       17'h0_0000,
		ms_tick:        1'b0,
		short_time:     {2{SHORT_TIME_RESET}},
		trip_level:     {2{TRIP_LEVEL_RESET}},
		trip_delay:     {2{TRIP_DELAY_RESET}},
		max_retry:      {2{MAX_RETRY_RESET}},
		retry_interval: {2{RETRY_INTERVAL_RESET}}
	};

	control_reg_type state_q;
	control_reg_type state_d;
	logic [7:0]      cond_s;
	logic            charger_ok;
	logic            inverse_set;
	logic [6:0]      danger;
	logic [6:0]      auto_on;
	logic [1:0]      ch_fault;
	logic [1:0]      ch_error;
	logic [1:0][15:0] ch_current;
	logic [1:0]      ch_short;
	logic            queried_request;

	function automatic logic index_valid(input logic [2:0] idx);
		return ((idx >= SW_PACK) && (idx <= SW_AUX)) || (idx == SW_PERIPH);
	endfunction : index_valid

	// ****************************************************************
	// Condition pins and channel protection
	// ****************************************************************
	input_sync #(
		.WIDTH (8)
	) u_sync (
		.clock    (clock),
		.rst_b    (rst_b),
		.async_in ({charger_present, charger_inverted, over_voltage,
			under_voltage, over_temperature, under_temperature,
			load_short, charge_short}),
		.sync_out (cond_s)
	);

	assign ch_current = {charge_current, load_current};
	assign ch_short = {cond_s[0], cond_s[1]};

	generate
		for (genvar c = 0; c < CHANNELS; c++)
		begin : g_channel
			overload_channel u_channel (
				.clock          (clock),
				.rst_b          (rst_b),
				.ms_tick        (state_q.ms_tick),
				.current        (ch_current[c]),
				.trip_level     (state_q.trip_level[c]),
				.trip_delay     (state_q.trip_delay[c]),
				.max_retry      (state_q.max_retry[c]),
				.retry_interval (state_q.retry_interval[c]),
				.short_time     (state_q.short_time[c]),
				.short_detect   (ch_short[c]),
				.error_clear    (error_clear),
				.fault          (ch_fault[c]),
				.overload_error (ch_error[c])
			);
		end
	endgenerate

	// ****************************************************************
	// Switch decisions
	// ****************************************************************
	assign charger_ok = cond_s[7] && !cond_s[6];
	assign inverse_set = state_q.mode[SW_CHARGE] &&
		state_q.request[SW_CHARGE] && cond_s[6];

	// Temperature faults open pack, load and charge, and aux on over temperature only;
	// voltage and current faults open only the path that carries the offending energy.
	always_comb
	begin
		danger = 7'h00;
		danger[SW_PACK] = cond_s[3] || cond_s[2];
		danger[SW_LOAD] = cond_s[4] || cond_s[3] || cond_s[2] || ch_fault[0];
		// The set condition opens the switch as well, so it never closes
		// for one cycle onto a reversed charger before the flag lands.
		danger[SW_CHARGE] = cond_s[5] || cond_s[3] || cond_s[2] ||
			ch_fault[1] || state_q.inverse_error || inverse_set;
		danger[SW_AUX] = cond_s[3];
	end

	always_comb
	begin
		auto_on = 7'h00;
		auto_on[SW_PACK] = mgmt_pack_enable;
		auto_on[SW_LOAD] = mgmt_load_enable;
		auto_on[SW_CHARGE] = charger_ok;
		auto_on[SW_AUX] = mgmt_aux_enable;
	end

	assign queried_request = index_valid(query_index) &&
		state_q.request[query_index];

	always_comb
	begin
		state_d = state_q;
		if (mode_write && index_valid(mode_index))
			state_d.mode[mode_index] = mode_value;
		// Stored whatever the mode; applied only while manual.
		if (request_write && index_valid(request_index))
			state_d.request[request_index] = request_value;
		if (config_write && (config_channel == CH_LOAD ||
			config_channel == CH_CHARGE))
		begin
			case (config_item)
				CFG_SHORT_TIME:
					state_d.short_time[config_channel[1]] = config_value[1:0];
				CFG_TRIP_LEVEL:
					state_d.trip_level[config_channel[1]] = config_value;
				CFG_TRIP_DELAY:
					state_d.trip_delay[config_channel[1]] = config_value;
				CFG_MAX_RETRY:
					state_d.max_retry[config_channel[1]] = config_value[7:0];
				CFG_RETRY_INTERVAL:
					state_d.retry_interval[config_channel[1]] = config_value;
				default:
					state_d.short_time = state_q.short_time;
			endcase
		end
		// Set wins over clear so a persisting fault is not lost.
		state_d.inverse_error = inverse_set ||
			(state_q.inverse_error && !error_clear);
		for (int i = 1; i <= 4; i++)
			state_d.sw[i] = !danger[i] && (state_q.mode[i] == MODE_MANUAL ?
				state_q.request[i] : auto_on[i]);
		state_d.sw[SW_PERIPH] = state_q.mode[SW_PERIPH] &&
			state_q.request[SW_PERIPH];
		state_d.query_request = queried_request;
		state_d.query_actual = index_valid(query_index) &&
			state_q.sw[query_index];
		state_d.ms_tick = state_q.ms_count == 17'(MS_CYCLES_P - 1);
		state_d.ms_count = state_d.ms_tick ? 17'h0_0000 :
			17'(state_q.ms_count + 17'h0_0001);
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			state_q <= CONTROL_RESET;
		else
			state_q <= state_d;
	end

	assign pack_on = state_q.sw[SW_PACK];
	assign load_on = state_q.sw[SW_LOAD];
	assign charge_on = state_q.sw[SW_CHARGE];
	assign aux_on = state_q.sw[SW_AUX];
	assign periph_on = state_q.sw[SW_PERIPH];
	assign query_request = state_q.query_request;
	assign query_actual = state_q.query_actual;
	assign inverse_charger_error = state_q.inverse_error;
	assign load_overload_error = ch_error[0];
	assign charge_overload_error = ch_error[1];

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	property p_default_modes;
		$rose(rst_b) |-> state_q.mode == MODE_RESET && !periph_on;
	endproperty
	a_default_modes: assert property (p_default_modes)
		else $error("modes not at defaults after reset");

	property p_manual_follows;
		state_q.mode[SW_LOAD] && !danger[SW_LOAD] |=>
			load_on == $past(state_q.request[SW_LOAD]);
	endproperty
	a_manual_follows: assert property (p_manual_follows)
		else $error("manual load does not follow request");

	property p_danger_off;
		danger[SW_CHARGE] |=> !charge_on;
	endproperty
	a_danger_off: assert property (p_danger_off)
		else $error("charge switch on under danger");

	property p_charge_auto;
		!state_q.mode[SW_CHARGE] && charger_ok && !danger[SW_CHARGE] |=>
			charge_on;
	endproperty
	a_charge_auto: assert property (p_charge_auto)
		else $error("automatic charge switch ignored charger");

	property p_charge_manual;
		state_q.mode[SW_CHARGE] && !state_q.request[SW_CHARGE] |=>
			!charge_on;
	endproperty
	a_charge_manual: assert property (p_charge_manual)
		else $error("manual charge closed without request");

	property p_inverse;
		inverse_set |=> inverse_charger_error ##1 !charge_on;
	endproperty
	a_inverse: assert property (p_inverse)
		else $error("inverse charger not forced off");

	property p_store;
		request_write && index_valid(request_index) && request_value |=>
			state_q.request[$past(request_index)];
	endproperty
	a_store: assert property (p_store)
		else $error("request was not stored");

	property p_query;
		request_write && index_valid(request_index) &&
			query_index == request_index ##1
			query_index == $past(query_index) |=>
			query_request == $past(request_value, 2);
	endproperty
	a_query: assert property (p_query)
		else $error("query does not report stored request");

	property p_periph_off;
		!state_q.mode[SW_PERIPH] |=> !periph_on;
	endproperty
	a_periph_off: assert property (p_periph_off)
		else $error("peripheral supply on in always off mode");

	c_manual_charge: cover property (state_q.mode[SW_CHARGE] ##1 charge_on);
	c_inverse_clear: cover property (inverse_charger_error ##1
		!inverse_charger_error);
	c_auto_charge: cover property (!state_q.mode[SW_CHARGE] && charge_on);
	c_load_trip: cover property ($rose(load_overload_error));

endmodule : power_switch_control

`default_nettype wire

// [logic/power_switch_pkg.sv]
// Purpose: Shared constants and types of the power switch control block.
// Assumes: One 100 MHz clock; commands arrive from logic on that clock.
// Notes:   Switch index values double as bit positions in the switch vectors.
//
// Overview of operation
// - Pack, load, charge, aux start automatic.
// - Mode takes index 1..4, 0 auto, 1 manual.
// - Manual switch follows user request, not management.
// - Danger turns switch off despite manual mode.
// - Auto charge closes on charger; manual does not.
// - Manual charge on with inverted charger: error, off.
// - After error clear, switch follows stored request again.
// - Query returns stored request, 0 off, 1 on.
// - Requests stored while automatic, not applied, reported.
// - Actual switch state has its own query.
// - Short response per channel: quick, medium, slow, off.
// - Overload acts only after configured delay in ms.
// - After overload, lock off or reconnect with retries.
// - Per channel retry count and retry interval held.
// - Voltage and temperature limits open relevant switches.
// - Peripheral index 6: 0 always off, 1 manual.
// - Peripheral supply defaults to manual mode.
// - Each switch owns a bit; 1 enables.

package power_switch_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLOCK_PERIOD_NS = 10;
	localparam int unsigned MS_TIME_NS = 1_000_000;
	localparam int unsigned MS_CYCLES = MS_TIME_NS / CLOCK_PERIOD_NS;
	localparam int unsigned SHORT_QUICK_NS = 10;
	localparam int unsigned SHORT_MEDIUM_NS = 100;
	localparam int unsigned SHORT_SLOW_NS = 1000;
	localparam logic [7:0] SHORT_QUICK_CYCLES =
		8'((SHORT_QUICK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [7:0] SHORT_MEDIUM_CYCLES =
		8'((SHORT_MEDIUM_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
	localparam logic [7:0] SHORT_SLOW_CYCLES =
		8'((SHORT_SLOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

	// ****************************************************************
	// Switch indices and modes
	// ****************************************************************
	localparam logic [2:0] SW_PACK = 3'h1;
	localparam logic [2:0] SW_LOAD = 3'h2;
	localparam logic [2:0] SW_CHARGE = 3'h3;
	localparam logic [2:0] SW_AUX = 3'h4;
	localparam logic [2:0] SW_PERIPH = 3'h6;
	localparam logic MODE_AUTO = 1'b0;
	localparam logic MODE_MANUAL = 1'b1;
	localparam logic [6:0] MODE_RESET = 7'h40;
	localparam logic [6:0] REQUEST_RESET = 7'h00;

	// ****************************************************************
	// Channel configuration
	// ****************************************************************
	localparam logic [1:0] CH_LOAD = 2'h1;
	localparam logic [1:0] CH_CHARGE = 2'h2;
	localparam int unsigned CHANNELS = 2;

	typedef enum logic [1:0] {
		SHORT_QUICK = 2'h0,
		SHORT_MEDIUM = 2'h1,
		SHORT_SLOW = 2'h2,
		SHORT_DISABLED = 2'h3
	} short_speed_type;

	typedef enum logic [2:0] {
		CFG_SHORT_TIME = 3'h0,
		CFG_TRIP_LEVEL = 3'h1,
		CFG_TRIP_DELAY = 3'h2,
		CFG_MAX_RETRY = 3'h3,
		CFG_RETRY_INTERVAL = 3'h4
	} config_item_type;

	localparam logic [1:0] SHORT_TIME_RESET = 2'h0;
	localparam logic [15:0] TRIP_LEVEL_RESET = 16'hFFFF;
	localparam logic [15:0] TRIP_DELAY_RESET = 16'h01F4;
	localparam logic [7:0] MAX_RETRY_RESET = 8'h00;
	localparam logic [15:0] RETRY_INTERVAL_RESET = 16'h03E8;

	typedef enum logic [3:0] {
		CH_ARMED = 4'h1,
		CH_RETRY_WAIT = 4'h2,
		CH_LOCKED = 4'h4,
		CH_SPARE = 4'h8
	} channel_state_type;

endpackage : power_switch_pkg

// [logic/input_sync.sv]
// Purpose: Two-stage synchroniser for asynchronous condition pins.
// Assumes: Each bit is an independent level.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none

module input_sync #(
	parameter int unsigned WIDTH = 8
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_type;

	sync_state_type state_q;
	sync_state_type state_d;

	always_comb
	begin
		state_d = state_q;
		state_d.stage1 = async_in;
		state_d.stage2 = state_q.stage1;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			state_q <= '0;
		else
			state_q <= state_d;
	end

	assign sync_out = state_q.stage2;

endmodule : input_sync

`default_nettype wire

// [logic/overload_channel.sv]
// Purpose: Overload and short trip with delayed retry for one channel.
// Assumes: ms_tick pulses once per millisecond.
// Notes:   Retries restart from zero only after an error clear.
`timescale 1ns/1ps
`default_nettype none

module overload_channel
	import power_switch_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        ms_tick,
	input  wire logic [15:0] current,
	input  wire logic [15:0] trip_level,
	input  wire logic [15:0] trip_delay,
	input  wire logic [7:0]  max_retry,
	input  wire logic [15:0] retry_interval,
	input  wire logic [1:0]  short_time,
	input  wire logic        short_detect,
	input  wire logic        error_clear,
	output var  logic        fault,
	output var  logic        overload_error
);

	typedef struct packed {
		channel_state_type state;
		logic [15:0]       ms_count;
		logic [7:0]        short_count;
		logic [7:0]        retries;
		logic              error;
	} channel_reg_type;

	channel_reg_type state_q;
	channel_reg_type state_d;
	logic over;
	logic short_trip;
	logic over_trip;

	function automatic logic [7:0] short_limit(input logic [1:0] code);
		case (code)
			SHORT_QUICK:  return SHORT_QUICK_CYCLES;
			SHORT_MEDIUM: return SHORT_MEDIUM_CYCLES;
			default:      return SHORT_SLOW_CYCLES;
		endcase
	endfunction : short_limit

	assign over = current > trip_level;
	assign over_trip = over && (state_q.ms_count >= trip_delay);
	assign short_trip = short_detect && (short_time != SHORT_DISABLED) &&
		(8'(state_q.short_count + 8'h01) >= short_limit(short_time));

	always_comb
	begin
		state_d = state_q;
		if (error_clear)
			state_d.error = 1'b0;
		case (state_q.state)
			CH_ARMED:
			begin
				state_d.short_count = short_detect ?
					8'(state_q.short_count + 8'h01) : 8'h00;
				if (!over)
					state_d.ms_count = 16'h0000;
				else if (ms_tick)
					state_d.ms_count = 16'(state_q.ms_count + 16'h0001);
				if (over_trip || short_trip)
				begin
					state_d.error = 1'b1;
					state_d.ms_count = 16'h0000;
					state_d.short_count = 8'h00;
					// Lock when the retry budget is spent.
					if (state_q.retries < max_retry)
						state_d.state = CH_RETRY_WAIT;
					else
						state_d.state = CH_LOCKED;
				end
			end
			CH_RETRY_WAIT:
			begin
				if (state_q.ms_count >= retry_interval)
				begin
					state_d.state = CH_ARMED;
					state_d.ms_count = 16'h0000;
					state_d.retries = 8'(state_q.retries + 8'h01);
				end
				else if (ms_tick)
					state_d.ms_count = 16'(state_q.ms_count + 16'h0001);
			end
			CH_LOCKED:
			begin
				if (error_clear)
				begin
					state_d.state = CH_ARMED;
					state_d.retries = 8'h00;
				end
			end
			default:
				state_d.state = CH_LOCKED;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			state_q <= '{CH_ARMED, 16'h0000, 8'h00, 8'h00, 1'b0};
		else
			state_q <= state_d;
	end

	assign fault = state_q.state != CH_ARMED;
	assign overload_error = state_q.error;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	property p_locked_holds;
		state_q.state == CH_LOCKED && !error_clear |=>
			state_q.state == CH_LOCKED;
	endproperty
	a_locked_holds: assert property (p_locked_holds)
		else $error("locked channel left without clear");

	property p_trip_cause;
		$rose(fault) |-> $past(over_trip) || $past(short_trip);
	endproperty
	a_trip_cause: assert property (p_trip_cause)
		else $error("channel tripped without cause");

	property p_retry_return;
		state_q.state == CH_RETRY_WAIT &&
			state_q.ms_count >= retry_interval |=>
			state_q.state == CH_ARMED && !fault;
	endproperty
	a_retry_return: assert property (p_retry_return)
		else $error("retry interval did not reconnect");

	c_retry: cover property (state_q.state == CH_RETRY_WAIT ##1
		state_q.state == CH_ARMED);
	c_lock: cover property ($rose(state_q.state == CH_LOCKED));

endmodule : overload_channel

`default_nettype wire

// [verification/host_model.sv]
// Purpose: Host that issues switch mode and request commands.
// Assumes: Commands are driven at the falling edge of clock.
// Notes:   Each strobe stands over exactly one rising edge.
`timescale 1ns/1ps
`default_nettype none

module host_model (
	input  wire logic       clock,
	output var  logic       mode_write,
	output var  logic [2:0] mode_index,
	output var  logic       mode_value,
	output var  logic       request_write,
	output var  logic [2:0] request_index,
	output var  logic       request_value
);
	initial
	begin
		mode_write = 1'b0;
		mode_index = 3'h0;
		mode_value = 1'b0;
		request_write = 1'b0;
		request_index = 3'h0;
		request_value = 1'b0;
	end

	// Released fields are inverted so nothing leans on stale values.
	task automatic set_mode(input logic [2:0] idx, input logic val);
		@(negedge clock);
		mode_index = idx;
		mode_value = val;
		mode_write = 1'b1;
		@(negedge clock);
		mode_write = 1'b0;
		mode_index = ~idx;
		mode_value = ~val;
	endtask : set_mode

	task automatic set_req(input logic [2:0] idx, input logic val);
		@(negedge clock);
		request_index = idx;
		request_value = val;
		request_write = 1'b1;
		@(negedge clock);
		request_write = 1'b0;
		request_index = ~idx;
		request_value = ~val;
	endtask : set_req
endmodule : host_model
`default_nettype wire

// [verification/power_switch_control_tb.sv]
// Purpose: Self-checking bench of the power switch control block.
// Assumes: Inputs change at the falling edge; ms shortened to 10 cycles.
// Notes:   Waits of a few cycles cover the 2FF plus register latency.
`timescale 1ns/1ps
`default_nettype none

module power_switch_control_tb;
	import power_switch_pkg::*;
	logic clock, rst_b, mode_write, mode_value, request_write, request_value;
	logic [2:0] mode_index, request_index, query_index;
	logic query_request, query_actual, config_write, error_clear;
	logic [1:0] config_channel;
	config_item_type config_item;
	logic [15:0] config_value, load_current, charge_current;
	logic mgmt_pack_enable, mgmt_load_enable, mgmt_aux_enable;
	logic charger_present, charger_inverted, over_voltage, under_voltage;
	logic over_temperature, under_temperature, load_short, charge_short;
	logic pack_on, load_on, charge_on, aux_on, periph_on;
	logic inverse_charger_error, load_overload_error, charge_overload_error;
	int fail_count, compares, cycles;

	host_model hst (.clock, .mode_write, .mode_index, .mode_value,
		.request_write, .request_index, .request_value);

	power_switch_control #(.MS_CYCLES_P(10)) DUT (.clock, .rst_b,
		.mode_write, .mode_index, .mode_value, .request_write,
		.request_index, .request_value, .query_index, .query_request,
		.query_actual, .config_write, .config_channel, .config_item,
		.config_value, .mgmt_pack_enable, .mgmt_load_enable,
		.mgmt_aux_enable, .load_current, .charge_current,
		.charger_present, .charger_inverted, .over_voltage, .under_voltage,
		.over_temperature, .under_temperature, .load_short, .charge_short,
		.error_clear, .pack_on, .load_on, .charge_on, .aux_on, .periph_on,
		.inverse_charger_error, .load_overload_error,
		.charge_overload_error);

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic complete_run();
		if (fail_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run

	// The run should need well under 2000 cycles.
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			fail_count++;
			complete_run();
		end
	end

	task automatic chk(input logic exp, input logic act);
		compares++;
		if (act !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED at %0t: exp %h got %h", $time, exp, act);
		end
	endtask : chk

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clock);
	endtask : wait_cyc

	task automatic cfg(input logic [1:0] ch, input config_item_type it,
		input logic [15:0] v);
		@(negedge clock);
		config_channel = ch;
		config_item = it;
		config_value = v;
		config_write = 1'b1;
		@(negedge clock);
		config_write = 1'b0;
	endtask : cfg

	task automatic clear_errors();
		@(negedge clock);
		error_clear = 1'b1;
		@(negedge clock);
		error_clear = 1'b0;
		wait_cyc(3);
	endtask : clear_errors

	task automatic t_defaults();
		chk(1'b0, pack_on | load_on | charge_on | aux_on | periph_on);
		chk(1'b0, inverse_charger_error | load_overload_error);
		mgmt_pack_enable = 1'b1;
		mgmt_aux_enable = 1'b1;
		wait_cyc(3);
		chk(1'b1, pack_on);
		chk(1'b1, aux_on);
	endtask : t_defaults

	task automatic t_load();
		hst.set_req(SW_LOAD, 1'b1);
		query_index = SW_LOAD;
		wait_cyc(3);
		chk(1'b1, query_request);
		chk(1'b0, load_on);
		chk(1'b0, query_actual);
		hst.set_mode(SW_LOAD, MODE_MANUAL);
		wait_cyc(3);
		chk(1'b1, load_on);
		chk(1'b1, query_actual);
		under_voltage = 1'b1;
		wait_cyc(4);
		chk(1'b0, load_on);
		under_voltage = 1'b0;
		wait_cyc(4);
		chk(1'b1, load_on);
	endtask : t_load

	task automatic t_charge();
		charger_present = 1'b1;
		wait_cyc(4);
		chk(1'b1, charge_on);
		hst.set_mode(SW_CHARGE, MODE_MANUAL);
		wait_cyc(3);
		chk(1'b0, charge_on);
		charger_inverted = 1'b1;
		hst.set_req(SW_CHARGE, 1'b1);
		wait_cyc(4);
		chk(1'b1, inverse_charger_error);
		chk(1'b0, charge_on);
		charger_inverted = 1'b0;
		wait_cyc(4);
		chk(1'b0, charge_on);
		clear_errors();
		chk(1'b0, inverse_charger_error);
		chk(1'b1, charge_on);
	endtask : t_charge

	task automatic t_periph();
		query_index = SW_PERIPH;
		hst.set_req(SW_PERIPH, 1'b1);
		wait_cyc(3);
		chk(1'b1, periph_on);
		hst.set_mode(SW_PERIPH, 1'b0);
		wait_cyc(3);
		chk(1'b0, periph_on);
		chk(1'b1, query_request);
	endtask : t_periph

	// Max retry keeps its reset value 0, so a trip locks the channel.
	task automatic t_overload();
		cfg(CH_LOAD, CFG_TRIP_LEVEL, 16'h0010);
		cfg(CH_LOAD, CFG_TRIP_DELAY, 16'h0000);
		load_current = 16'h0020;
		wait_cyc(4);
		chk(1'b1, load_overload_error);
		chk(1'b0, load_on);
		load_current = 16'h0000;
		wait_cyc(30);
		chk(1'b0, load_on);
		clear_errors();
		chk(1'b0, load_overload_error);
		chk(1'b1, load_on);
	endtask : t_overload

	// One retry is allowed: the first trip reconnects, the second locks.
	task automatic t_retry();
		cfg(CH_CHARGE, CFG_MAX_RETRY, 16'h0001);
		cfg(CH_CHARGE, CFG_RETRY_INTERVAL, 16'h0002);
		cfg(CH_CHARGE, CFG_TRIP_LEVEL, 16'h0010);
		cfg(CH_CHARGE, CFG_TRIP_DELAY, 16'h0002);
		charge_current = 16'h0020;
		wait_cyc(8);
		chk(1'b0, charge_overload_error);
		wait_cyc(16);
		chk(1'b1, charge_overload_error);
		chk(1'b0, charge_on);
		charge_current = 16'h0000;
		wait_cyc(30);
		chk(1'b1, charge_on);
		cfg(CH_CHARGE, CFG_SHORT_TIME, 16'h0003);
		charge_short = 1'b1;
		wait_cyc(6);
		chk(1'b1, charge_on);
		cfg(CH_CHARGE, CFG_SHORT_TIME, 16'h0000);
		wait_cyc(6);
		chk(1'b0, charge_on);
		charge_short = 1'b0;
		wait_cyc(30);
		chk(1'b0, charge_on);
		clear_errors();
		chk(1'b0, charge_overload_error);
		chk(1'b1, charge_on);
	endtask : t_retry

	initial
	begin
		{rst_b, config_write, error_clear, mgmt_pack_enable} = '0;
		{mgmt_load_enable, mgmt_aux_enable, charger_present} = '0;
		{charger_inverted, over_voltage, under_voltage} = '0;
		{over_temperature, under_temperature, load_short, charge_short} = '0;
		{config_channel, config_value, load_current, charge_current} = '0;
		config_item = CFG_SHORT_TIME;
		query_index = 3'h0;
		{fail_count, compares, cycles} = '0;
		wait_cyc(2);
		rst_b = 1'b1;
		t_defaults();
		t_load();
		t_charge();
		t_periph();
		t_overload();
		t_retry();
		complete_run();
	end
endmodule : power_switch_control_tb
`default_nettype wire
